/* design/cluster_bus_pkg.sv */
// package for the cluster bus access multiplexer
// assumes one clock domain and a simple valid/ready register bus
package cluster_bus_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // address windows of the cluster (base and mask per window)
  localparam logic [15:0] ADC_BASE      = 16'hf000;
  localparam logic [15:0] ADC_MASK      = 16'hf000;
  localparam logic [15:0] FIFO_MEM_BASE = 16'h8000;
  localparam logic [15:0] FIFO_MEM_MASK = 16'hc000;
  localparam logic [15:0] SEQ_RAM_BASE  = 16'hc000;
  localparam logic [15:0] SEQ_RAM_MASK  = 16'hf000;
  localparam logic [15:0] MULT_RAM_BASE = 16'h4000;
  localparam logic [15:0] MULT_RAM_MASK = 16'hc000;
  localparam logic [15:0] FILT_BUF_BASE = 16'h3000;
  localparam logic [15:0] FILT_BUF_MASK = 16'hff00;

  // single-wait registers
  localparam logic [15:0] GLOBAL_RESET_REG    = 16'h0008;
  localparam logic [15:0] CLUSTER_CLOCK_CFG   = 16'h000c;
  localparam logic [15:0] BROADCAST_RESET_REG = 16'h0100;
  localparam logic [15:0] CAPTURE_UNIT_RESET  = 16'h0200;
  localparam logic [15:0] TIMER_GRP0_GLB_CTRL = 16'h0300;
  localparam logic [15:0] TIMER_GRP1_GLB_CTRL = 16'h0304;
  localparam logic [15:0] ADV_TIMER_GLB_CTRL  = 16'h0400;
  localparam logic [15:0] PULSE_MULT_CTRL_ONE = 16'h0500;
  // multi-wait trigger registers of the sequencer
  localparam logic [15:0] SEQ_TRIGGER_CLEAR   = 16'h0600;
  localparam logic [15:0] SEQ_TRIGGER_SET     = 16'h0604;

  // wait cycles per class
  localparam logic [3:0] WAIT_ZERO  = 4'h0;
  localparam logic [3:0] WAIT_ONE   = 4'h1;
  localparam logic [3:0] WAIT_MULTI = 4'h3;

  typedef enum logic [1:0] {
    CLS_ZERO  = 2'h0,
    CLS_ONE   = 2'h1,
    CLS_MULTI = 2'h2
  } access_class_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CPU  = 2'b01,
    ST_SEQ  = 2'b10
  } grant_state_type;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_type;

  typedef struct packed {
    logic              error;
    logic [DATA_W-1:0] rdata;
  } bus_rsp_type;

  // decode the timing class of an address
  function automatic access_class_type classify(input logic [ADDR_W-1:0] a);
    if ((a & FIFO_MEM_MASK) == FIFO_MEM_BASE || (a & SEQ_RAM_MASK) == SEQ_RAM_BASE
        || (a & MULT_RAM_MASK) == MULT_RAM_BASE || (a & FILT_BUF_MASK) == FILT_BUF_BASE
        || a == SEQ_TRIGGER_CLEAR || a == SEQ_TRIGGER_SET)
      return CLS_MULTI;
    if (a == GLOBAL_RESET_REG || a == CLUSTER_CLOCK_CFG || a == BROADCAST_RESET_REG
        || a == CAPTURE_UNIT_RESET || a == TIMER_GRP0_GLB_CTRL
        || a == TIMER_GRP1_GLB_CTRL || a == ADV_TIMER_GLB_CTRL
        || a == PULSE_MULT_CTRL_ONE)
      return CLS_ONE;
    return CLS_ZERO;
  endfunction : classify

  // host-only memory windows
  function automatic logic hostOnly(input logic [ADDR_W-1:0] a);
    return ((a & FIFO_MEM_MASK) == FIFO_MEM_BASE) || ((a & SEQ_RAM_MASK) == SEQ_RAM_BASE);
  endfunction : hostOnly

  function automatic logic isAdc(input logic [ADDR_W-1:0] a);
    return (a & ADC_MASK) == ADC_BASE;
  endfunction : isAdc

endpackage : cluster_bus_pkg

/* design/sequencer_bus_master.sv */
// sequencer bus master: one-entry buffer for register accesses, direct adc path
// assumes the sequencer holds its request until seqReady
`timescale 1ns/1ns
module sequencer_bus_master
  import cluster_bus_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // sequencer side
  input  wire logic        seqValid,
  input  bus_req_type      seqReq,
  output logic             seqReady,
  output logic             seqRspValid,
  output bus_rsp_type      seqRsp,
  input  wire logic        portDisable,
  // adc side
  output logic             adcValid,
  output bus_req_type      adcReq,
  input  wire logic        adcRspValid,
  input  bus_rsp_type      adcRsp,
  // buffered request towards the multiplexer
  output logic             bufValid,
  output bus_req_type      bufReq,
  input  wire logic        bufTaken,
  input  wire logic        bufDone,
  input  bus_rsp_type      bufRsp
);

  logic        bufFull_q;
  bus_req_type bufEntry_q;
  logic        adcPend_q;
  logic        isAdcReq;

  assign isAdcReq = isAdc(seqReq.addr);

  // adc requests bypass the buffer; one sequencer access in flight so answers never collide
  assign seqReady = !portDisable && seqValid && !bufFull_q && !adcPend_q;  // [R12] [R11]
  assign adcValid = seqValid && isAdcReq && !portDisable && !adcPend_q
                    && !bufFull_q;  // [R6] [R12]
  assign adcReq   = seqReq;
  assign bufValid = bufFull_q;
  assign bufReq   = bufEntry_q;

  // buffer entry holds an access until the bus has answered it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bufFull_q  <= 1'b0;
      bufEntry_q <= '0;
    end else if (seqReady && !isAdcReq) begin
      bufFull_q  <= 1'b1;  // [R11]
      bufEntry_q <= seqReq;
    end else if (bufDone) begin
      bufFull_q  <= 1'b0;
    end
  end

  // adc access outstanding flag
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      adcPend_q <= 1'b0;
    end else if (adcValid) begin
      adcPend_q <= !adcRspValid;
    end else if (adcRspValid) begin
      adcPend_q <= 1'b0;
    end
  end

  // response back to the sequencer from flip-flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      seqRspValid <= 1'b0;
      seqRsp      <= '0;
    end else begin
      seqRspValid <= adcRspValid || bufDone;
      seqRsp      <= adcRspValid ? adcRsp : bufRsp;
    end
  end

  a_take_with_entry: assert property (@(posedge mclk) disable iff (!rst_b)
    bufTaken |-> bufFull_q)  // [R11]
    else $error("grant without a buffered access");

  a_adc_no_buffer: assert property (@(posedge mclk) disable iff (!rst_b)
    (seqReady && isAdcReq) |=> $stable(bufFull_q) || !bufFull_q)  // [R12]
    else $error("adc access entered buffer");

endmodule : sequencer_bus_master

/* design/cluster_bus_access_mux.sv */
// cluster bus multiplexer between host and sequencer master on the register bus
// assumes targets answer after the wait cycles of their class
// Notes on behaviour
// R1: every sequencer master access is classed as zero, one or multi wait by its address.
// R2: most registers and all adc reads complete with no wait cycle.
// R3: the eight listed control registers take exactly one wait cycle.
// R4: memories and the two sequencer trigger registers take more than one wait cycle.
// R5: fifo memory and sequencer program memory are reachable only from the host.
// R6: sequencer adc operations use the same master port as its register accesses.
// R7: software only uses the master port disable to shut the port off for good.
// R8: routing-unit traffic of the sequencer is independent of the master port.
// R9: bus users avoid unproven mixes of sequencer and host traffic.
// R10: the multiplexer arbitrates host against sequencer, sequencer first by default.
// R11: the sequencer master buffers accesses that cannot be served at once.
// R12: adc accesses are recognised by address and bypass the buffers.
// R13: zero wait finishes in one cycle, one wait in two, longer ones in more.
// R14: a grant is held until its access has its final answer.
`timescale 1ns/1ns
module cluster_bus_access_mux
  import cluster_bus_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // host port
  input  wire logic        hostValid,
  input  bus_req_type      hostReq,
  output logic             hostReady,
  output logic             hostRspValid,
  output bus_rsp_type      hostRsp,
  // sequencer port
  input  wire logic        seqValid,
  input  bus_req_type      seqReq,
  output logic             seqReady,
  output logic             seqRspValid,
  output bus_rsp_type      seqRsp,
  input  wire logic        portDisable,
  input  wire logic        hostPriority,
  // adc port
  output logic             adcValid,
  output bus_req_type      adcReq,
  input  wire logic        adcRspValid,
  input  bus_rsp_type      adcRsp,
  // cluster register bus
  output logic             busSel,
  output bus_req_type      busReq,
  output access_class_type busClass,
  input  wire logic [DATA_W-1:0] busRdata,
  output logic             busSeqOwner
);

  ////////////////////////////////////////////////////////////////////////////
  grant_state_type  state_q;
  grant_state_type  state_d;
  logic [3:0]       waitCnt_q;
  logic [3:0]       waitNeed;
  bus_req_type      cur_q;
  logic             curErr_q;
  logic             bufValid;
  bus_req_type      bufReq;
  logic             bufDone;
  logic             grantSeq;
  logic             grantCpu;
  logic             finish;
  bus_rsp_type      busRsp;

  // sequencer master with its buffer and adc bypass; routing-unit traffic never passes here
  sequencer_bus_master seqMaster (  // [R6] [R8]
    .mclk        (mclk),
    .rst_b       (rst_b),
    .seqValid    (seqValid),
    .seqReq      (seqReq),
    .seqReady    (seqReady),
    .seqRspValid (seqRspValid),
    .seqRsp      (seqRsp),
    .portDisable (portDisable),  // [R7] treated as a static level
    .adcValid    (adcValid),
    .adcReq      (adcReq),
    .adcRspValid (adcRspValid),
    .adcRsp      (adcRsp),
    .bufValid    (bufValid),
    .bufReq      (bufReq),
    .bufTaken    (grantSeq),
    .bufDone     (bufDone),
    .bufRsp      (busRsp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // arbitration: sequencer first unless host priority is strapped
  always_comb begin
    grantSeq = 1'b0;
    grantCpu = 1'b0;
    if (state_q == ST_IDLE) begin
      if (bufValid && (!hostPriority || !hostValid)) begin
        grantSeq = 1'b1;  // [R10]
      end else if (hostValid) begin
        grantCpu = 1'b1;
      end
    end
  end

  // wait cycles needed by the granted access
  always_comb begin
    case (classify(cur_q.addr))  // [R1]
      CLS_ZERO:  waitNeed = WAIT_ZERO;   // [R2]
      CLS_ONE:   waitNeed = WAIT_ONE;    // [R3]
      CLS_MULTI: waitNeed = WAIT_MULTI;  // [R4]
      default:   waitNeed = WAIT_ZERO;
    endcase
  end

  assign finish = (state_q != ST_IDLE) && (waitCnt_q == waitNeed);  // [R13]

  // grant state machine, held until the final answer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (grantSeq) begin
          state_d = ST_SEQ;
        end else if (grantCpu) begin
          state_d = ST_CPU;
        end
      end
      ST_CPU:  if (finish) state_d = ST_IDLE;  // [R14]
      ST_SEQ:  if (finish) state_d = ST_IDLE;  // [R14]
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // latch the granted request; sequencer hits on host-only memory are errored
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cur_q    <= '0;
      curErr_q <= 1'b0;
    end else if (grantSeq) begin
      cur_q    <= bufReq;
      curErr_q <= hostOnly(bufReq.addr);  // [R5]
    end else if (grantCpu) begin
      cur_q    <= hostReq;
      curErr_q <= 1'b0;
    end
  end

  // wait cycle counter
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      waitCnt_q <= '0;
    end else if (state_q == ST_IDLE || finish) begin
      waitCnt_q <= '0;
    end else begin
      waitCnt_q <= waitCnt_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus drive: a blocked sequencer access never selects a target
  assign busSel      = (state_q != ST_IDLE) && !curErr_q;  // [R5]
  assign busReq      = cur_q;
  assign busClass    = classify(cur_q.addr);
  assign busSeqOwner = (state_q == ST_SEQ);
  assign busRsp      = '{error: curErr_q, rdata: (curErr_q ? '0 : busRdata)};
  assign bufDone     = finish && (state_q == ST_SEQ);
  assign hostReady   = grantCpu;

  // host response from flip-flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hostRspValid <= 1'b0;
      hostRsp      <= '0;
    end else begin
      hostRspValid <= finish && (state_q == ST_CPU);
      hostRsp      <= busRsp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_grantOne;
    (state_q == ST_IDLE) && (grantSeq || grantCpu) && (classify(bufReq.addr) == CLS_ONE)
      && grantSeq;
  endsequence

  a_seq_over_host: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_q == ST_IDLE && bufValid && hostValid && !hostPriority) |-> grantSeq)  // [R10]
    else $error("host granted over sequencer");

  a_zero_wait: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_q != ST_IDLE && waitCnt_q == 4'h0 && classify(cur_q.addr) == CLS_ZERO)
      |-> finish)  // [R2]
    else $error("zero wait access not finished");

  a_one_wait: assert property (@(posedge mclk) disable iff (!rst_b)
    s_grantOne |=> !finish ##1 finish)  // [R3]
    else $error("one wait access timing wrong");

  a_multi_wait: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_q != ST_IDLE && waitCnt_q == 4'h0 && classify(cur_q.addr) == CLS_MULTI)
      |-> !finish [*2] ##1 !finish ##1 finish)  // [R4]
    else $error("multi wait access timing wrong");

  a_grant_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_q != ST_IDLE && !finish) |=> $stable(state_q) && $stable(cur_q))  // [R14]
    else $error("grant changed before answer");

  a_host_only: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_q == ST_SEQ && hostOnly(cur_q.addr)) |-> !busSel)  // [R5]
    else $error("sequencer reached host-only memory");

  a_class_known: assert property (@(posedge mclk) disable iff (!rst_b)
    busSel |-> busClass inside {CLS_ZERO, CLS_ONE, CLS_MULTI})  // [R1]
    else $error("unclassed access");

  a_seq_reply: assert property (@(posedge mclk) disable iff (!rst_b)
    bufDone |=> seqRspValid)  // [R11]
    else $error("buffered access lost");

  a_adc_direct: assert property (@(posedge mclk) disable iff (!rst_b)
    (seqValid && isAdc(seqReq.addr) && seqReady) |-> adcValid)  // [R12]
    else $error("adc access not forwarded");

  a_host_first: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_q == ST_IDLE && hostValid && hostPriority) |-> grantCpu)  // [R10]
    else $error("sequencer granted over strapped host");

  a_no_grant_busy: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_q != ST_IDLE) |-> !hostReady && !grantSeq)  // [R14]
    else $error("new grant during an access");

endmodule : cluster_bus_access_mux

/* testbench/target_model.sv */
// register bus targets and adc of the cluster, answering at once
// assumes the multiplexer holds busSel and busReq for the whole access
`timescale 1ns/1ns
module target_model
  import cluster_bus_pkg::*;
(
  // clock
  input  wire logic              mclk,
  // register bus
  input  wire logic              busSel,
  input  bus_req_type            busReq,
  output logic [DATA_W-1:0]      busRdata,
  // adc
  input  wire logic              adcValid,
  input  bus_req_type            adcReq,
  output logic                   adcRspValid,
  output bus_rsp_type            adcRsp
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [DATA_W-1:0] noise_q;

  // changing pattern on released lines so stale data never looks valid
  always @(posedge mclk) begin
    noise_q <= noise_q + 32'h01010101;
  end
  initial noise_q = 32'h0;

  // read data tied to the address while selected
  assign busRdata = busSel ? {busReq.addr ^ 16'h5a5a, busReq.addr} : noise_q;

  // adc answers in the same cycle, never waits
  assign adcRspValid = adcValid;
  assign adcRsp = adcValid ? {1'b0, 16'hadc0, adcReq.addr} : {1'b1, ~noise_q};
endmodule : target_model

/* testbench/cluster_bus_access_mux_tb.sv */
// self-checking bench for the cluster bus multiplexer
// assumes the target model answers every bus access and adc read
`timescale 1ns/1ns
module cluster_bus_access_mux_tb;
  import cluster_bus_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  logic mclk = 0, rst_b = 0, hostValid = 0, seqValid = 0, portDisable = 0, hostPriority = 0;
  bus_req_type hostReq = '0, seqReq = '0, adcReq, busReq;
  bus_rsp_type hostRsp, seqRsp, adcRsp;
  logic hostReady, hostRspValid, seqReady, seqRspValid, adcValid, adcRspValid;
  logic busSel, busSeqOwner;
  logic [DATA_W-1:0] busRdata;
  access_class_type busClass;
  int miscompares = 0, n_compared = 0, cyc = 0;
  localparam logic [15:0] ADDRS [15] = '{16'h0010, 16'h2ffc, GLOBAL_RESET_REG,
    CLUSTER_CLOCK_CFG, BROADCAST_RESET_REG, CAPTURE_UNIT_RESET, TIMER_GRP0_GLB_CTRL,
    TIMER_GRP1_GLB_CTRL, ADV_TIMER_GLB_CTRL, PULSE_MULT_CTRL_ONE, 16'h4000, 16'h7ffc,
    16'h30fc, SEQ_TRIGGER_CLEAR, SEQ_TRIGGER_SET};

  // design and its far side
  cluster_bus_access_mux i_dut (.mclk(mclk), .rst_b(rst_b), .hostValid(hostValid),
    .hostReq(hostReq), .hostReady(hostReady), .hostRspValid(hostRspValid),
    .hostRsp(hostRsp), .seqValid(seqValid), .seqReq(seqReq), .seqReady(seqReady),
    .seqRspValid(seqRspValid), .seqRsp(seqRsp), .portDisable(portDisable),
    .hostPriority(hostPriority), .adcValid(adcValid), .adcReq(adcReq),
    .adcRspValid(adcRspValid), .adcRsp(adcRsp), .busSel(busSel), .busReq(busReq),
    .busClass(busClass), .busRdata(busRdata), .busSeqOwner(busSeqOwner));
  target_model i_tgt (.mclk(mclk), .busSel(busSel), .busReq(busReq), .busRdata(busRdata),
    .adcValid(adcValid), .adcReq(adcReq), .adcRspValid(adcRspValid), .adcRsp(adcRsp));

  // clock and hang guard
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (e !== g) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // one request from the host (s=0) or the sequencer (s=1), held until taken
  task automatic go(input bit s, input logic [15:0] a);
    int n;
    n = 0;
    @(posedge mclk);
    #1;
    if (s) begin seqValid = 1; seqReq = '{1'b0, a, 32'h0}; end
    else begin hostValid = 1; hostReq = '{1'b0, a, 32'h0}; end
    @(negedge mclk);
    while ((s ? seqReady : hostReady) !== 1'b1 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    chk("request taken", 1, n < 60);
    @(posedge mclk);
    #1;
    if (s) seqValid = 0;
    else hostValid = 0;
  endtask : go

  // follow one bus access and its answer
  task automatic watch(input logic own, input access_class_type c, input logic [15:0] a);
    int n, k;
    n = 0;
    k = 0;
    @(negedge mclk);
    while (busSel !== 1'b1 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    while (busSel === 1'b1 && k < 10) begin
      chk("busSeqOwner", own, busSeqOwner);
      chk("busClass", c, busClass);
      chk("busReq.addr", a, busReq.addr);
      k++;
      @(negedge mclk);
    end
    chk("busSel cycles", 1 + (c == CLS_ZERO ? WAIT_ZERO : c == CLS_ONE ? WAIT_ONE : WAIT_MULTI),
        k);
    chk("rsp valid", 1, own ? seqRspValid : hostRspValid);
    chk("rsp data", {a ^ 16'h5a5a, a}, own ? seqRsp.rdata : hostRsp.rdata);
  endtask : watch

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_classes();
    for (int i = 0; i < 15; i++) begin
      fork go(1, ADDRS[i]); join_none
      watch(1, i < 2 ? CLS_ZERO : i < 10 ? CLS_ONE : CLS_MULTI, ADDRS[i]);
    end
    $display("test classes done");
  endtask : t_classes

  task automatic t_host_only();
    int n;
    logic [15:0] a [2] = '{16'h8000, 16'hc004};
    for (int i = 0; i < 2; i++) begin
      n = 0;
      fork go(1, a[i]); join_none
      @(negedge mclk);
      while (seqRspValid !== 1'b1 && n < 20) begin
        chk("busSel", 0, busSel);
        @(negedge mclk);
        n++;
      end
      chk("seq error", 1, seqRsp.error);
      fork go(0, a[i]); join_none
      watch(0, CLS_MULTI, a[i]);
    end
    $display("test host only done");
  endtask : t_host_only

  task automatic t_adc();
    int n;
    n = 0;
    fork go(1, 16'hf010); join_none
    @(negedge mclk);
    while (adcValid !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk("adcReq.addr", 16'hf010, adcReq.addr);
    chk("busSel", 0, busSel);
    @(negedge mclk);
    chk("adc rsp valid", 1, seqRspValid);
    chk("adc rsp data", {16'hadc0, 16'hf010}, seqRsp.rdata);
    chk("busSel", 0, busSel);
    $display("test adc done");
  endtask : t_adc

  // host holds a long access while the sequencer and the host queue behind it
  task automatic t_priority(input logic pri);
    @(posedge mclk);
    #1;
    hostPriority = pri;
    fork
      begin go(0, 16'h4000); go(0, 16'h0020); end
      begin repeat (3) @(posedge mclk); go(1, 16'h0010); end
    join_none
    watch(0, CLS_MULTI, 16'h4000);
    if (!pri) begin
      watch(1, CLS_ZERO, 16'h0010);
      watch(0, CLS_ZERO, 16'h0020);
    end else begin
      watch(0, CLS_ZERO, 16'h0020);
      watch(1, CLS_ZERO, 16'h0010);
    end
    repeat (4) @(posedge mclk);
    $display("test priority %0d done", pri);
  endtask : t_priority

  // port shut off for good, never re-enabled
  task automatic t_disable();
    @(posedge mclk);
    #1;
    portDisable = 1;
    seqValid = 1;
    seqReq = '{1'b0, 16'h0010, 32'h0};
    for (int i = 0; i < 10; i++) begin
      if (i == 5) seqReq.addr = 16'hf010;
      @(negedge mclk);
      chk("seqReady", 0, seqReady);
      chk("adcValid", 0, adcValid);
      chk("busSel", 0, busSel);
      @(posedge mclk);
      #1;
    end
    seqValid = 0;
    $display("test disable done");
  endtask : t_disable

  // main sequence, one access at a time outside the priority case
  initial begin
    repeat (5) @(posedge mclk);
    #1;
    rst_b = 1;
    t_classes();
    t_host_only();
    t_adc();
    t_priority(0);
    t_priority(1);
    t_disable();
    wrap_up();
  end
endmodule : cluster_bus_access_mux_tb
